// ---- shared/cde_pkg.sv ----
package cde_pkg;

	// ----------------------------------------------------------------
	// Widths and instruction fields
	// ----------------------------------------------------------------
	localparam int DATA_W = 8;
	localparam int FADDR_W = 7;
	localparam int PC_W = 13;
	localparam int K_W = 11;
	localparam int INSTR_W = 14;
	localparam int OPC_HI = 13;
	localparam int OPC_LO = 11;
	localparam int DEST_BIT = 7;
	localparam int LATH_W = 5;
	localparam int LATH_HI = 4;
	localparam int LATH_LO = 3;
	localparam logic [DATA_W-1:0] ONE_B = 8'h01;
	localparam logic [DATA_W-1:0] ZERO_B = 8'h00;
	localparam logic [PC_W-1:0] ONE_PC = 13'h0001;

	// ----------------------------------------------------------------
	// Register map, byte addresses on the bus
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_INSTR = 8'h00;
	localparam logic [7:0] OFS_PC = 8'h04;
	localparam logic [7:0] OFS_ACC = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0C;
	localparam logic [7:0] OFS_LATCH = 8'h10;
	localparam logic [7:0] OFS_STACK = 8'h14;
	localparam logic [7:0] OFS_DADDR = 8'h18;
	localparam logic [7:0] OFS_DATA = 8'h1C;
	localparam logic [7:0] OFS_CYCLES = 8'h20;
	localparam int ST_Z_BIT = 0;
	localparam int ST_SKIP_BIT = 1;
	localparam int ST_BUSY_BIT = 2;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [PC_W-1:0] RST_PC = 13'h0000;
	localparam logic [DATA_W-1:0] RST_ACC = 8'h00;
	localparam logic [LATH_W-1:0] RST_LATCH = 5'h00;
	localparam logic [31:0] RST_WORD = 32'h00000000;

	// ----------------------------------------------------------------
	// Enumerations and carriers
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		OP_NOP = 3'b000,
		OP_INVERT = 3'b001,
		OP_ZREG = 3'b010,
		OP_ZACC = 3'b011,
		OP_CALL = 3'b100,
		OP_DEC = 3'b101,
		OP_DECSKIP = 3'b110,
		OP_RSVD = 3'b111
	} cde_op_e;

	typedef enum logic {
		ST_RUN = 1'b0,
		ST_SECOND = 1'b1
	} cde_state_e;

	typedef struct packed {
		logic read;
		logic write;
		logic [7:0] address;
		logic [31:0] writedata;
		logic [3:0] byteenable;
	} cde_avs_req_s;

	typedef struct packed {
		logic [31:0] readdata;
		logic waitrequest;
	} cde_avs_rsp_s;

	typedef struct packed {
		logic we;
		logic [FADDR_W-1:0] waddr;
		logic [DATA_W-1:0] wdata;
	} cde_rf_wr_s;

endpackage

// ---- core/cde_regfile.sv ----
`timescale 1ns/100ps
module cde_regfile #(
	parameter int DEPTH = 128
) (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic rst_n,
	// Write port.
	input wire cde_pkg::cde_rf_wr_s wr,
	// Read ports.
	input wire logic [cde_pkg::FADDR_W-1:0] raddr_a,
	input wire logic [cde_pkg::FADDR_W-1:0] raddr_b,
	output logic [cde_pkg::DATA_W-1:0] rdata_a,
	output logic [cde_pkg::DATA_W-1:0] rdata_b
);

	typedef struct packed {
		logic [DEPTH-1:0][cde_pkg::DATA_W-1:0] mem;
	} cde_rf_s;

	cde_rf_s r;
	cde_rf_s next_r;

	// Reads are combinational so an instruction sees its operand in the cycle it executes.
	assign rdata_a = r.mem[raddr_a];
	assign rdata_b = r.mem[raddr_b];

	// One write per cycle; the bus and the executor never write in the same cycle.
	always_comb begin
		next_r = r;
		if (wr.we) begin
			next_r.mem[wr.waddr] = wr.wdata;
		end
	end

	// Data registers clear at reset so reads never return unknowns.
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

endmodule

// ---- core/cde_exec.sv ----
// Design decisions made here: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/100ps
module cde_exec (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic rst_n,
	// Avalon-MM slave.
	input wire cde_pkg::cde_avs_req_s avs_req,
	output cde_pkg::cde_avs_rsp_s avs_rsp
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		cde_pkg::cde_state_e state;
		logic [cde_pkg::PC_W-1:0] pc;
		logic [cde_pkg::PC_W-1:0] stack_top_entry;
		logic [cde_pkg::DATA_W-1:0] acc;
		logic [cde_pkg::LATH_W-1:0] pc_high_latch;
		logic z;
		logic skip;
		logic [cde_pkg::FADDR_W-1:0] daddr;
		logic [cde_pkg::INSTR_W-1:0] last_instr;
		logic [31:0] cycles;
		logic rd_done;
		logic [31:0] rdata;
	} cde_core_s;

	cde_core_s r;
	cde_core_s next_r;

	logic [31:0] be_mask;
	logic wait_req;
	logic ex_go;
	logic ex_run;
	cde_pkg::cde_op_e op;
	logic dest;
	logic [cde_pkg::FADDR_W-1:0] faddr;
	logic [cde_pkg::DATA_W-1:0] f_val;
	logic [cde_pkg::DATA_W-1:0] bus_data;
	logic [cde_pkg::DATA_W-1:0] ex_res;
	cde_pkg::cde_rf_wr_s rf_wr;
	logic [31:0] rd_mux;

	// ----------------------------------------------------------------
	// Bus handshake
	// ----------------------------------------------------------------

	// Byte enables become a bit mask for read-modify-write of the PC, ACC, LATCH and DADDR registers.
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_be
			assign be_mask[gi*8 +: 8] = {8{avs_req.byteenable[gi]}};
		end
	endgenerate

	// Reads answer one cycle late from a flop; an instruction write stalls
	// during the second cycle of a call, which keeps the executor single-issue.
	always_comb begin
		if (avs_req.read) begin
			wait_req = ~r.rd_done;
		end else begin
			wait_req = avs_req.write && avs_req.address == cde_pkg::OFS_INSTR
				&& r.state == cde_pkg::ST_SECOND;
		end
	end

	assign avs_rsp.waitrequest = wait_req;
	assign avs_rsp.readdata = r.rdata;

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	assign ex_go = avs_req.write && !wait_req && avs_req.address == cde_pkg::OFS_INSTR;
	assign ex_run = ex_go && !r.skip;
	assign op = cde_pkg::cde_op_e'(avs_req.writedata[cde_pkg::OPC_HI:cde_pkg::OPC_LO]);
	assign dest = avs_req.writedata[cde_pkg::DEST_BIT];
	assign faddr = avs_req.writedata[cde_pkg::FADDR_W-1:0];

	// Result of the register operation, computed from the operand read this cycle.
	always_comb begin
		case (op)
			cde_pkg::OP_INVERT: ex_res = ~f_val;
			cde_pkg::OP_DEC, cde_pkg::OP_DECSKIP: ex_res = f_val - cde_pkg::ONE_B;
			default: ex_res = cde_pkg::ZERO_B;
		endcase
	end

	// Data register write: the executor, or the bus data window.
	always_comb begin
		rf_wr.we = 1'b0;
		rf_wr.waddr = faddr;
		rf_wr.wdata = ex_res;
		if (ex_run) begin
			case (op)
				cde_pkg::OP_INVERT, cde_pkg::OP_DEC, cde_pkg::OP_DECSKIP: rf_wr.we = dest;
				cde_pkg::OP_ZREG: rf_wr.we = 1'b1;
				default: rf_wr.we = 1'b0;
			endcase
		end else if (avs_req.write && avs_req.address == cde_pkg::OFS_DATA
			&& avs_req.byteenable[0]) begin
			rf_wr.we = 1'b1;
			rf_wr.waddr = r.daddr;
			rf_wr.wdata = avs_req.writedata[cde_pkg::DATA_W-1:0];
		end
	end

	// The file depth follows the address field, so every encodable register exists.
	cde_regfile #(
		.DEPTH(2 ** cde_pkg::FADDR_W)
	) i_cde_regfile (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.wr(rf_wr),
		.raddr_a(faddr),
		.raddr_b(r.daddr),
		.rdata_a(f_val),
		.rdata_b(bus_data)
	);

	// ----------------------------------------------------------------
	// Read mux
	// ----------------------------------------------------------------

	// Unmapped addresses read as zero; narrow registers sit in the low bits.
	always_comb begin
		case (avs_req.address)
			cde_pkg::OFS_INSTR: rd_mux = 32'(r.last_instr);
			cde_pkg::OFS_PC: rd_mux = 32'(r.pc);
			cde_pkg::OFS_ACC: rd_mux = 32'(r.acc);
			cde_pkg::OFS_STATUS: rd_mux = 32'({r.state == cde_pkg::ST_SECOND, r.skip, r.z});
			cde_pkg::OFS_LATCH: rd_mux = 32'(r.pc_high_latch);
			cde_pkg::OFS_STACK: rd_mux = 32'(r.stack_top_entry);
			cde_pkg::OFS_DADDR: rd_mux = 32'(r.daddr);
			cde_pkg::OFS_DATA: rd_mux = 32'(bus_data);
			cde_pkg::OFS_CYCLES: rd_mux = r.cycles;
			default: rd_mux = cde_pkg::RST_WORD;
		endcase
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		logic [31:0] wv;
		wv = 32'h00000000;
		next_r = r;
		next_r.rd_done = avs_req.read && !r.rd_done;
		if (avs_req.read && !r.rd_done) begin
			next_r.rdata = rd_mux;
		end
		// The second cycle of a call issues nothing new.
		if (r.state == cde_pkg::ST_SECOND) begin
			next_r.state = cde_pkg::ST_RUN;
			next_r.cycles = r.cycles + 32'h00000001;
		end
		if (ex_go) begin
			next_r.last_instr = avs_req.writedata[cde_pkg::INSTR_W-1:0];
			next_r.cycles = r.cycles + 32'h00000001;
			next_r.pc = r.pc + cde_pkg::ONE_PC;
			// A skipped instruction is discarded and runs as a no-op.
			next_r.skip = 1'b0;
		end
		if (ex_run) begin
			case (op)
				cde_pkg::OP_CALL: begin
					next_r.stack_top_entry = r.pc + cde_pkg::ONE_PC;
					next_r.pc = {r.pc_high_latch[cde_pkg::LATH_HI:cde_pkg::LATH_LO],
						avs_req.writedata[cde_pkg::K_W-1:0]};
					next_r.state = cde_pkg::ST_SECOND;
				end
				cde_pkg::OP_INVERT, cde_pkg::OP_DEC: begin
					if (!dest) begin
						next_r.acc = ex_res;
					end
					next_r.z = ex_res == cde_pkg::ZERO_B;
				end
				cde_pkg::OP_DECSKIP: begin
					if (!dest) begin
						next_r.acc = ex_res;
					end
					next_r.skip = ex_res == cde_pkg::ZERO_B;
				end
				cde_pkg::OP_ZREG: next_r.z = 1'b1;
				cde_pkg::OP_ZACC: begin
					next_r.acc = cde_pkg::ZERO_B;
					next_r.z = 1'b1;
				end
				default: next_r.z = r.z;
			endcase
		end
		// Register writes from software merge under the byte enables.
		if (avs_req.write && !wait_req) begin
			case (avs_req.address)
				cde_pkg::OFS_PC: begin
					wv = (32'(r.pc) & ~be_mask) | (avs_req.writedata & be_mask);
					next_r.pc = wv[cde_pkg::PC_W-1:0];
				end
				cde_pkg::OFS_ACC: begin
					wv = (32'(r.acc) & ~be_mask) | (avs_req.writedata & be_mask);
					next_r.acc = wv[cde_pkg::DATA_W-1:0];
				end
				cde_pkg::OFS_STATUS: begin
					if (avs_req.byteenable[0]) begin
						next_r.z = avs_req.writedata[cde_pkg::ST_Z_BIT];
					end
				end
				cde_pkg::OFS_LATCH: begin
					wv = (32'(r.pc_high_latch) & ~be_mask) | (avs_req.writedata & be_mask);
					next_r.pc_high_latch = wv[cde_pkg::LATH_W-1:0];
				end
				cde_pkg::OFS_DADDR: begin
					wv = (32'(r.daddr) & ~be_mask) | (avs_req.writedata & be_mask);
					next_r.daddr = wv[cde_pkg::FADDR_W-1:0];
				end
				default: wv = 32'h00000000;
			endcase
		end
	end

	// Single register stage for the whole core state.
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			r <= '0;
			r.pc <= cde_pkg::RST_PC;
			r.acc <= cde_pkg::RST_ACC;
			r.pc_high_latch <= cde_pkg::RST_LATCH;
			r.state <= cde_pkg::ST_RUN;
		end else begin
			r <= next_r;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);

	// Call: push, target and two cycles. The stall check also proves that a write
	// arriving in the second cycle is never executed early.
	AST_CALL_PUSH: assert property (
		ex_run && op == cde_pkg::OP_CALL |=> r.stack_top_entry == $past(r.pc) + cde_pkg::ONE_PC)
		else $error("Call did not push the return address.");
	AST_CALL_LOW: assert property (
		ex_run && op == cde_pkg::OP_CALL
		|=> r.pc[cde_pkg::K_W-1:0] == $past(avs_req.writedata[cde_pkg::K_W-1:0]))
		else $error("Call immediate not loaded into low counter bits.");
	AST_CALL_HIGH: assert property (
		ex_run && op == cde_pkg::OP_CALL
		|=> r.pc[cde_pkg::PC_W-1:cde_pkg::K_W]
		== $past(r.pc_high_latch[cde_pkg::LATH_HI:cde_pkg::LATH_LO]))
		else $error("Call upper counter bits not from the high latch.");
	AST_CALL_TWO: assert property (
		ex_run && op == cde_pkg::OP_CALL
		|=> r.state == cde_pkg::ST_SECOND && r.z == $past(r.z) ##1 r.state == cde_pkg::ST_RUN)
		else $error("Call did not take exactly two cycles or moved a flag.");
	AST_CALL_STALL: assert property (
		r.state == cde_pkg::ST_SECOND && avs_req.write && avs_req.address == cde_pkg::OFS_INSTR
		|-> avs_rsp.waitrequest)
		else $error("Instruction write was not held off in the second call cycle.");
	AST_CALL_NO_DATA: assert property (
		ex_run && op == cde_pkg::OP_CALL |-> !rf_wr.we)
		else $error("Call wrote a data register.");

	// Invert: the result goes to exactly one destination.
	AST_INVERT: assert property (
		ex_run && op == cde_pkg::OP_INVERT && !dest |=> r.acc == ~$past(f_val))
		else $error("Invert result missing from the accumulator.");
	AST_INVERT_REG: assert property (
		ex_run && op == cde_pkg::OP_INVERT && dest |-> rf_wr.we && rf_wr.wdata == ~f_val)
		else $error("Invert result missing from the register.");
	AST_INVERT_ACC_KEEP: assert property (
		ex_run && op == cde_pkg::OP_INVERT && dest |=> r.acc == $past(r.acc))
		else $error("Invert into the register disturbed the accumulator.");

	// The zero flag follows the result of the flag-setting operations.
	AST_ZERO_FLAG: assert property (
		ex_run && (op == cde_pkg::OP_INVERT || op == cde_pkg::OP_DEC)
		|=> r.z == ($past(ex_res) == 8'h00))
		else $error("Zero flag does not follow the result.");

	// Clears: the register clear writes zero, the accumulator clear writes no register.
	AST_ZREG: assert property (
		ex_run && op == cde_pkg::OP_ZREG |-> rf_wr.we && rf_wr.wdata == 8'h00 ##1 r.z)
		else $error("Register clear did not write zero and set the flag.");
	AST_ZREG_ADDR: assert property (
		ex_run && op == cde_pkg::OP_ZREG
		|-> rf_wr.waddr == avs_req.writedata[cde_pkg::FADDR_W-1:0])
		else $error("Register clear wrote the wrong register.");
	AST_ZACC: assert property (
		ex_run && op == cde_pkg::OP_ZACC |=> r.acc == 8'h00 && r.z)
		else $error("Accumulator clear failed.");
	AST_ZACC_NO_WRITE: assert property (
		ex_run && op == cde_pkg::OP_ZACC |-> !rf_wr.we)
		else $error("Accumulator clear wrote a data register.");

	// Decrement: the destination bit selects register or accumulator.
	AST_DEC_REG: assert property (
		ex_run && op == cde_pkg::OP_DEC && dest |-> rf_wr.we && rf_wr.wdata == f_val - 8'h01)
		else $error("Decrement did not write the register.");
	AST_DEC_ACC: assert property (
		ex_run && op == cde_pkg::OP_DEC && !dest |=> r.acc == $past(f_val) - cde_pkg::ONE_B)
		else $error("Decrement result missing from the accumulator.");
	AST_DEC_ACC_ONLY: assert property (
		ex_run && op == cde_pkg::OP_DEC && !dest |-> !rf_wr.we)
		else $error("Decrement into the accumulator also wrote the register.");

	// Decrement-and-skip: the zero flag does not move, and only an operand of one arms the skip,
	// because that is the only operand whose decrement is zero.
	AST_DECSKIP_FLAG: assert property (
		ex_run && op == cde_pkg::OP_DECSKIP |=> r.z == $past(r.z))
		else $error("Decrement-and-skip changed the zero flag.");
	AST_DECSKIP_REG: assert property (
		ex_run && op == cde_pkg::OP_DECSKIP && dest
		|-> rf_wr.we && rf_wr.wdata == f_val - cde_pkg::ONE_B)
		else $error("Decrement-and-skip did not write the register.");
	AST_SKIP_ARM: assert property (
		ex_run && op == cde_pkg::OP_DECSKIP |=> r.skip == ($past(f_val) == cde_pkg::ONE_B))
		else $error("Skip not armed exactly on a zero result.");
	AST_SKIP_NOP: assert property (
		ex_go && r.skip |-> !rf_wr.we ##1 !r.skip && r.acc == $past(r.acc))
		else $error("Skipped instruction was not discarded.");
	AST_SKIP_PC: assert property (
		ex_go && r.skip |=> r.pc == $past(r.pc) + cde_pkg::ONE_PC)
		else $error("Discarded instruction did not advance the program counter.");

	// Decode: register address field and destination bit.
	AST_DECODE_ADDR: assert property (
		ex_run && op == cde_pkg::OP_DEC && dest
		|-> rf_wr.waddr == avs_req.writedata[cde_pkg::FADDR_W-1:0])
		else $error("Register address field decoded wrongly.");
	AST_DECODE_DEST: assert property (
		ex_run && (op == cde_pkg::OP_INVERT || op == cde_pkg::OP_DEC || op == cde_pkg::OP_DECSKIP)
		|-> rf_wr.we == avs_req.writedata[cde_pkg::DEST_BIT])
		else $error("Destination bit decoded wrongly.");

	// Main scenarios that the tests must reach at least once.
	COV_CALL: cover property (ex_run && op == cde_pkg::OP_CALL);
	COV_SKIP_TAKEN: cover property (ex_run && op == cde_pkg::OP_DECSKIP
		&& ex_res == 8'h00 ##[1:20] ex_go);
	COV_INVERT_REG: cover property (ex_run && op == cde_pkg::OP_INVERT && dest);
	COV_CALL_STALL: cover property (r.state == cde_pkg::ST_SECOND && avs_req.write
		&& avs_req.address == cde_pkg::OFS_INSTR);
	COV_NOP: cover property (ex_run && (op == cde_pkg::OP_NOP || op == cde_pkg::OP_RSVD));

endmodule

// ---- bench/cde_exec_test.sv ----
`timescale 1ns/100ps
module cde_exec_test;

	// ----------------------------------------------------------------
	// Clock, reset and bus signals
	// ----------------------------------------------------------------
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	cde_pkg::cde_avs_req_s avs_req = '0;
	cde_pkg::cde_avs_rsp_s avs_rsp;
	int failures = 0;
	int n_compared = 0;
	logic [31:0] c0;
	logic [31:0] c1;

	cde_exec i_cde_exec (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.avs_req(avs_req),
		.avs_rsp(avs_rsp)
	);

	// The clock runs at 50 MHz.
	initial begin
		forever #10 clk_sys = ~clk_sys;
	end

	// ----------------------------------------------------------------
	// Bus tasks
	// ----------------------------------------------------------------
	// A write holds until waitrequest is seen low, then lets one edge pass so the
	// strobe is never lowered and raised within one time step.
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		avs_req.write <= 1'b1;
		avs_req.address <= a;
		avs_req.writedata <= d;
		avs_req.byteenable <= 4'hF;
		@(posedge clk_sys);
		while (avs_rsp.waitrequest !== 1'b0) @(posedge clk_sys);
		avs_req.write <= 1'b0;
		@(posedge clk_sys);
	endtask

	// A read takes its data at the edge where waitrequest is low.
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		avs_req.read <= 1'b1;
		avs_req.address <= a;
		@(posedge clk_sys);
		while (avs_rsp.waitrequest !== 1'b0) @(posedge clk_sys);
		d = avs_rsp.readdata;
		avs_req.read <= 1'b0;
		@(posedge clk_sys);
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		rd(a, d);
		n_compared++;
		if (d !== e) begin
			failures++;
			$display("BAD %0t read at %h gave %h, expected %h", $time, a, d, e);
		end
	endtask

	// Data registers are reached through the address and window registers.
	task automatic put_reg(input logic [6:0] f, input logic [7:0] v);
		wr(cde_pkg::OFS_DADDR, {25'h0000000, f});
		wr(cde_pkg::OFS_DATA, {24'h000000, v});
	endtask

	task automatic chk_reg(input logic [6:0] f, input logic [7:0] v);
		wr(cde_pkg::OFS_DADDR, {25'h0000000, f});
		rd_chk(cde_pkg::OFS_DATA, {24'h000000, v});
	endtask

	function automatic logic [31:0] ins(input logic [2:0] op, input logic d, input logic [6:0] f);
		return {18'h00000, op, 3'h0, d, f};
	endfunction

	task automatic exe(input logic [31:0] w);
		wr(cde_pkg::OFS_INSTR, w);
	endtask

	// Two instructions back to back: the strobe stays up, so the second one
	// meets the stall of a call's second cycle.
	task automatic exe2(input logic [31:0] w1, input logic [31:0] w2);
		avs_req.write <= 1'b1;
		avs_req.address <= cde_pkg::OFS_INSTR;
		avs_req.writedata <= w1;
		avs_req.byteenable <= 4'hF;
		@(posedge clk_sys);
		while (avs_rsp.waitrequest !== 1'b0) @(posedge clk_sys);
		avs_req.writedata <= w2;
		@(posedge clk_sys);
		while (avs_rsp.waitrequest !== 1'b0) @(posedge clk_sys);
		avs_req.write <= 1'b0;
		@(posedge clk_sys);
	endtask

	// ----------------------------------------------------------------
	// Verdict
	// ----------------------------------------------------------------
	task automatic stop_test;
		$display("compares %0d, mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// The whole sequence needs well under a thousand cycles.
	initial begin
		repeat (5000) @(posedge clk_sys);
		failures++;
		$display("BAD %0t watchdog expired", $time);
		stop_test;
	end

	// ----------------------------------------------------------------
	// Test sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (6) @(posedge clk_sys);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk_sys);
		rd_chk(cde_pkg::OFS_STATUS, 32'h0);
		wr(8'h24, 32'hFFFFFFFF);
		rd_chk(8'h24, 32'h0);
		// Invert into the accumulator, then back into the register.
		put_reg(7'h7F, 8'hA5);
		exe(ins(cde_pkg::OP_INVERT, 1'b0, 7'h7F));
		rd_chk(cde_pkg::OFS_ACC, 32'h5A);
		chk_reg(7'h7F, 8'hA5);
		rd_chk(cde_pkg::OFS_STATUS, 32'h0);
		put_reg(7'h01, 8'hFF);
		exe(ins(cde_pkg::OP_INVERT, 1'b1, 7'h01));
		chk_reg(7'h01, 8'h00);
		rd_chk(cde_pkg::OFS_ACC, 32'h5A);
		rd_chk(cde_pkg::OFS_STATUS, 32'h1);
		// Decrement to zero in place, then wrap into the accumulator.
		put_reg(7'h00, 8'h01);
		exe(ins(cde_pkg::OP_DEC, 1'b1, 7'h00));
		chk_reg(7'h00, 8'h00);
		rd_chk(cde_pkg::OFS_STATUS, 32'h1);
		exe(ins(cde_pkg::OP_DEC, 1'b0, 7'h00));
		rd_chk(cde_pkg::OFS_ACC, 32'hFF);
		chk_reg(7'h00, 8'h00);
		rd_chk(cde_pkg::OFS_STATUS, 32'h0);
		// Accumulator clear ignores whatever sits in the operand field.
		exe(ins(cde_pkg::OP_ZACC, 1'b1, 7'h55));
		rd_chk(cde_pkg::OFS_ACC, 32'h0);
		rd_chk(cde_pkg::OFS_STATUS, 32'h1);
		// Register clear from a cleared zero flag; register 7F must survive.
		put_reg(7'h40, 8'h33);
		wr(cde_pkg::OFS_STATUS, 32'h0);
		exe(ins(cde_pkg::OP_ZREG, 1'b0, 7'h40));
		chk_reg(7'h40, 8'h00);
		rd_chk(cde_pkg::OFS_STATUS, 32'h1);
		chk_reg(7'h7F, 8'hA5);
		// Decrement-and-skip without a zero result keeps the zero flag set.
		put_reg(7'h10, 8'h02);
		exe(ins(cde_pkg::OP_DECSKIP, 1'b0, 7'h10));
		rd_chk(cde_pkg::OFS_ACC, 32'h01);
		chk_reg(7'h10, 8'h02);
		rd_chk(cde_pkg::OFS_STATUS, 32'h1);
		// A zero result must not set the flag and must swallow the next instruction.
		wr(cde_pkg::OFS_STATUS, 32'h0);
		put_reg(7'h11, 8'h01);
		wr(cde_pkg::OFS_PC, 32'h0100);
		rd(cde_pkg::OFS_CYCLES, c0);
		exe(ins(cde_pkg::OP_DECSKIP, 1'b1, 7'h11));
		chk_reg(7'h11, 8'h00);
		rd_chk(cde_pkg::OFS_STATUS, 32'h2);
		exe(ins(cde_pkg::OP_ZACC, 1'b0, 7'h00));
		rd_chk(cde_pkg::OFS_ACC, 32'h01);
		rd_chk(cde_pkg::OFS_STATUS, 32'h0);
		rd_chk(cde_pkg::OFS_PC, 32'h0102);
		rd_chk(cde_pkg::OFS_CYCLES, c0 + 32'h2);
		// Call with the top immediate; latch bits 4..3 both set.
		wr(cde_pkg::OFS_STATUS, 32'h1);
		wr(cde_pkg::OFS_PC, 32'h0123);
		wr(cde_pkg::OFS_LATCH, 32'h18);
		rd(cde_pkg::OFS_CYCLES, c0);
		exe({18'h00000, cde_pkg::OP_CALL, 11'h7FF});
		rd_chk(cde_pkg::OFS_STACK, 32'h0124);
		rd_chk(cde_pkg::OFS_PC, 32'h1FFF);
		rd_chk(cde_pkg::OFS_STATUS, 32'h1);
		rd(cde_pkg::OFS_CYCLES, c1);
		n_compared++;
		if (c1 !== c0 + 32'h2) begin
			failures++;
			$display("BAD %0t call cycle count %0d after %0d", $time, c1, c0);
		end
		// Only latch bits 4..3 may reach the program counter.
		wr(cde_pkg::OFS_STATUS, 32'h0);
		wr(cde_pkg::OFS_PC, 32'h0AAA);
		wr(cde_pkg::OFS_LATCH, 32'h0F);
		exe({18'h00000, cde_pkg::OP_CALL, 11'h555});
		rd_chk(cde_pkg::OFS_STACK, 32'h0AAB);
		rd_chk(cde_pkg::OFS_PC, 32'h0D55);
		rd_chk(cde_pkg::OFS_STATUS, 32'h0);
		// No-op and reserved codes only advance the counter; the word reads back.
		exe(ins(cde_pkg::OP_NOP, 1'b1, 7'h20));
		exe(ins(cde_pkg::OP_RSVD, 1'b0, 7'h20));
		rd_chk(cde_pkg::OFS_PC, 32'h0D57);
		rd_chk(cde_pkg::OFS_ACC, 32'h01);
		rd_chk(cde_pkg::OFS_INSTR, ins(cde_pkg::OP_RSVD, 1'b0, 7'h20));
		// An instruction written during the second call cycle waits, then runs.
		wr(cde_pkg::OFS_LATCH, 32'h00);
		wr(cde_pkg::OFS_PC, 32'h0005);
		rd(cde_pkg::OFS_CYCLES, c0);
		exe2({18'h00000, cde_pkg::OP_CALL, 11'h100}, ins(cde_pkg::OP_ZACC, 1'b0, 7'h00));
		rd_chk(cde_pkg::OFS_STACK, 32'h0006);
		rd_chk(cde_pkg::OFS_PC, 32'h0101);
		rd_chk(cde_pkg::OFS_ACC, 32'h0);
		rd_chk(cde_pkg::OFS_STATUS, 32'h1);
		rd_chk(cde_pkg::OFS_CYCLES, c0 + 32'h3);
		stop_test;
	end

endmodule
